// *** common/pld_pkg.sv ***
// Constants, register map and field layout of the PLL lock-detect block.
// Assumes a single 10 MHz system clock and an AHB-Lite register bus.
// What this block does
// - Three-bit delay cells on reference, feedback paths
// - Lock after programmed consecutive in-window compares
// - One compare beyond unlock threshold drops lock
// - Unlock threshold always wider than lock threshold
// - Window from range bit, antibacklash, count
// - Lock result muxable onto three pins
// - Current-source mode chosen by six-bit select
// - Current source on when locked, grounded otherwise
// - Any false lock discharges pin at once
// - Pin comparator readable high or low
// - Analog lock only on lock pin, two variants
// - N-channel variant rests high, low pulses
// - P-channel variant rests low, high pulses
// - Fixed divide bypasses swallow; one-one bypasses both
// - Feedback ratio is P times B plus A
package pld_pkg;

  // ==========================================================
  // Register indices and byte-address width
  localparam int          ADDR_W       = 12;
  localparam logic [9:0]  IDX_PRESCALE = 10'h016;
  localparam logic [9:0]  IDX_STAT_SEL = 10'h017;
  localparam logic [9:0]  IDX_LK_CTRL  = 10'h018;
  localparam logic [9:0]  IDX_DELAY    = 10'h019;
  localparam logic [9:0]  IDX_LK_SEL   = 10'h01a;
  localparam logic [9:0]  IDX_RM_SEL   = 10'h01b;
  localparam logic [9:0]  IDX_A_CNT    = 10'h020;
  localparam logic [9:0]  IDX_B_CNT    = 10'h021;
  localparam logic [9:0]  IDX_STATUS   = 10'h022;
  localparam logic [9:0]  IDX_N_RATIO  = 10'h023;

  // ==========================================================
  // Field positions
  localparam int STAT_SEL_LSB = 2;
  localparam int ABP_LSB      = 0;
  localparam int LK_CNT_LSB   = 5;
  localparam int LK_RANGE_BIT = 4;
  localparam int LK_DIS_BIT   = 3;
  localparam int R_DLY_LSB    = 0;
  localparam int N_DLY_LSB    = 3;

  // ==========================================================
  // Reset values
  localparam logic [2:0]  RST_PRESCALE = 3'h0;
  localparam logic [7:0]  RST_STAT_SEL = 8'h00;
  localparam logic [6:0]  RST_LK_CTRL  = 7'h00;
  localparam logic [5:0]  RST_DELAY    = 6'h00;
  localparam logic [5:0]  RST_LK_SEL   = 6'h00;
  localparam logic [4:0]  RST_RM_SEL   = 5'h00;
  localparam logic [5:0]  RST_A_CNT    = 6'h00;
  localparam logic [12:0] RST_B_CNT    = 13'h0001;

  // ==========================================================
  // Pin select codes
  localparam logic [5:0] LKSEL_DIG   = 6'h00;
  localparam logic [5:0] LKSEL_ANA_N = 6'h01;
  localparam logic [5:0] LKSEL_ANA_P = 6'h02;
  localparam logic [5:0] LKSEL_CSRC  = 6'h04;
  localparam logic [4:0] SEL_LOW     = 5'h00;
  localparam logic [4:0] SEL_DIG     = 5'h01;
  localparam logic [4:0] SEL_CMP_HI  = 5'h02;
  localparam logic [4:0] SEL_CMP_LO  = 5'h03;

  // ==========================================================
  // Lock counts and thresholds, in phase-error code units
  localparam logic [7:0] LK_COUNT_0   = 8'h05;
  localparam logic [7:0] LK_COUNT_1   = 8'h10;
  localparam logic [7:0] LK_COUNT_2   = 8'h40;
  localparam logic [7:0] LK_COUNT_3   = 8'hff;
  localparam logic [7:0] LOCK_THR_HI  = 8'h20;
  localparam logic [7:0] LOCK_THR_LO  = 8'h08;
  localparam logic [7:0] ABP_STEP     = 8'h04;

  // Prescaler mode codes: fixed 1/2/3, then dual 2/3 .. 32/33
  typedef enum logic [2:0] {
    PM_FD1, PM_FD2, PM_FD3, PM_DM2, PM_DM4, PM_DM8, PM_DM16, PM_DM32
  } pld_pmode_t;

endpackage : pld_pkg

// *** design/pld_fb_ratio.sv ***
// Feedback divide ratio from prescaler mode and the two counters.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module pld_fb_ratio
  import pld_pkg::*;
(
  input  wire logic [2:0]  pmode,
  input  wire logic [5:0]  a_cnt,
  input  wire logic [12:0] b_cnt,
  output logic [5:0]       p_val,
  output logic             bypass_a,
  output logic             bypass_all,
  output logic [17:0]      n_ratio
);

  logic [17:0] prod;
  logic        fixed;

  always_comb
  begin
    fixed = 1'b0;
    case (pld_pmode_t'(pmode))
      PM_FD1:  begin p_val = 6'h01; fixed = 1'b1; end
      PM_FD2:  begin p_val = 6'h02; fixed = 1'b1; end
      PM_FD3:  begin p_val = 6'h03; fixed = 1'b1; end
      PM_DM2:  p_val = 6'h02;
      PM_DM4:  p_val = 6'h04;
      PM_DM8:  p_val = 6'h08;
      PM_DM16: p_val = 6'h10;
      PM_DM32: p_val = 6'h20;
      default: p_val = 6'h01;
    endcase
    bypass_a   = fixed;
    bypass_all = fixed && p_val == 6'h01 && b_cnt == 13'h0001;
    prod       = 18'(p_val * b_cnt);
    n_ratio    = bypass_all ? 18'h00001 :
                 bypass_a   ? prod : 18'(prod + a_cnt);
  end

endmodule : pld_fb_ratio

// *** design/pld_lock_det.sv ***
// Consecutive-compare lock detector with hysteresis.
// Assumes one pulse on cmp_event per phase comparison.
`timescale 1ns/1ns
module pld_lock_det
  import pld_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             enable,
  input  wire logic             cmp_event,
  input  wire logic [7:0]       phase_err,
  input  wire logic [7:0]       lock_thr,
  input  wire logic [7:0]       unlock_thr,
  input  wire logic [CNT_W-1:0] need_cnt,
  output logic                  lock_q,
  output logic [CNT_W-1:0]      cnt_q
);

  if (CNT_W < 8)
  begin : g_cnt_w_bad
    $error("pld_lock_det: CNT_W below 8");
  end

  // ==========================================================
  // Counter and lock flag
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_q <= 1'b0;
      cnt_q  <= '0;
    end
    else if (ce)
    begin
      if (!enable)
      begin
        lock_q <= 1'b0;
        cnt_q  <= '0;
      end
      else if (cmp_event)
      begin
        if (lock_q && phase_err > unlock_thr)
        begin
          lock_q <= 1'b0;
          cnt_q  <= '0;
        end
        else if (phase_err < lock_thr)
        begin
          if (cnt_q < need_cnt)
            cnt_q <= cnt_q + 1'b1;
          // Widened sum so a full counter cannot wrap to zero
          if ({1'b0, cnt_q} + 1'b1 >= {1'b0, need_cnt})
            lock_q <= 1'b1;
        end
        else
          cnt_q <= '0;
      end
    end
  end

endmodule : pld_lock_det

// *** design/pld_lock_top.sv ***
// Top of the PLL lock-detect and feedback-divider setup block.
// Assumes AHB-Lite master on sys_clk, pins synchronous to sys_clk.
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module pld_lock_top
  import pld_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  input  wire logic              cmp_event,
  input  wire logic [7:0]        phase_err,
  input  wire logic              cmp_mismatch,
  input  wire logic              lk_comparator_in,
  input  wire logic              lock_indicator_pin_i,
  output logic                   lock_indicator_pin_o,
  output logic                   lock_indicator_pin_oe,
  output logic                   lk_current_src_on,
  output logic                   status_pin,
  output logic                   reference_monitor_pin,
  output logic                   digital_lock_result,
  output logic [2:0]             ref_delay_code,
  output logic [2:0]             fb_delay_code,
  output logic [5:0]             fb_prescale,
  output logic [5:0]             fb_swallow,
  output logic [12:0]            fb_main,
  output logic                   fixed_divide_mode,
  output logic                   fb_bypass_all,
  output logic [17:0]            fb_ratio
);

  if (CNT_W != 8)
  begin : g_cnt_w_bad
    $error("pld_lock_top: CNT_W must be 8");
  end

  // ==========================================================
  // Registers
  logic [2:0]       prescale_q;
  logic [7:0]       stat_sel_q;
  logic [6:0]       lk_ctrl_q;
  logic [5:0]       delay_q;
  logic [5:0]       lk_sel_q;
  logic [4:0]       rm_sel_q;
  logic [5:0]       a_cnt_q;
  logic [12:0]      b_cnt_q;
  logic             wr_q;
  logic             rd_q;
  logic [9:0]       idx_q;
  logic             lock_w;
  logic [CNT_W-1:0] cnt_w;
  logic [7:0]       lock_thr;
  logic [7:0]       unlock_thr;
  logic [7:0]       need_cnt;
  logic [5:0]       p_w;
  logic             byp_a_w;
  logic             byp_all_w;
  logic [17:0]      n_w;
  logic [31:0]      rdata_d;
  logic             take;
  logic [5:0]       st_sel;

  assign take   = hsel && htrans[1] && hready;
  assign st_sel = stat_sel_q[7:STAT_SEL_LSB];

  // ==========================================================
  // Bus slave: writes zero-wait, reads one wait state
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      idx_q     <= '0;
      hreadyout <= 1'b1;
      hrdata    <= '0;
      hresp     <= 1'b0;
    end
    else if (ce)
    begin
      if (rd_q)
      begin
        hrdata    <= rdata_d;
        hreadyout <= 1'b1;
        rd_q      <= 1'b0;
      end
      else
      begin
        wr_q <= take && hwrite;
        if (take)
        begin
          idx_q <= haddr[11:2];
          if (!hwrite)
          begin
            rd_q      <= 1'b1;
            hreadyout <= 1'b0;
          end
        end
      end
    end
  end

  // Unmapped words read zero and ignore writes
  always_comb
  begin
    rdata_d = 32'h0;
    case (idx_q)
      IDX_PRESCALE: rdata_d[2:0]  = prescale_q;
      IDX_STAT_SEL: rdata_d[7:0]  = stat_sel_q;
      IDX_LK_CTRL:  rdata_d[6:0]  = lk_ctrl_q;
      IDX_DELAY:    rdata_d[5:0]  = delay_q;
      IDX_LK_SEL:   rdata_d[5:0]  = lk_sel_q;
      IDX_RM_SEL:   rdata_d[4:0]  = rm_sel_q;
      IDX_A_CNT:    rdata_d[5:0]  = a_cnt_q;
      IDX_B_CNT:    rdata_d[12:0] = b_cnt_q;
      IDX_STATUS:   rdata_d[9:0]  = {cnt_w, lk_comparator_in, lock_w};
      IDX_N_RATIO:  rdata_d[17:0] = fb_ratio;
      default:      rdata_d       = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prescale_q <= RST_PRESCALE;
      stat_sel_q <= RST_STAT_SEL;
      lk_ctrl_q  <= RST_LK_CTRL;
      delay_q    <= RST_DELAY;
      lk_sel_q   <= RST_LK_SEL;
      rm_sel_q   <= RST_RM_SEL;
      a_cnt_q    <= RST_A_CNT;
      b_cnt_q    <= RST_B_CNT;
    end
    else if (ce && wr_q && !rd_q)
    begin
      case (idx_q)
        IDX_PRESCALE: prescale_q <= hwdata[2:0];
        IDX_STAT_SEL: stat_sel_q <= hwdata[7:0];
        IDX_LK_CTRL:  lk_ctrl_q  <= hwdata[6:0];
        IDX_DELAY:    delay_q    <= hwdata[5:0];
        IDX_LK_SEL:   lk_sel_q   <= hwdata[5:0];
        IDX_RM_SEL:   rm_sel_q   <= hwdata[4:0];
        IDX_A_CNT:    a_cnt_q    <= hwdata[5:0];
        IDX_B_CNT:    b_cnt_q    <= hwdata[12:0];
        default:      ;
      endcase
    end
  end

  // ==========================================================
  // Lock window: range bit, antibacklash width, count
  always_comb
  begin
    lock_thr = (lk_ctrl_q[LK_RANGE_BIT] ? LOCK_THR_LO : LOCK_THR_HI) +
               8'(ABP_STEP * stat_sel_q[ABP_LSB +: 2]);
    // Doubling keeps a real gap above the lock window
    unlock_thr = 8'(lock_thr << 1);
    case (lk_ctrl_q[LK_CNT_LSB +: 2])
      2'h0:    need_cnt = LK_COUNT_0;
      2'h1:    need_cnt = LK_COUNT_1;
      2'h2:    need_cnt = LK_COUNT_2;
      default: need_cnt = LK_COUNT_3;
    endcase
  end

  pld_lock_det #(
    .CNT_W (CNT_W)
  ) u_det (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .ce         (ce),
    .enable     (!lk_ctrl_q[LK_DIS_BIT]),
    .cmp_event  (cmp_event),
    .phase_err  (phase_err),
    .lock_thr   (lock_thr),
    .unlock_thr (unlock_thr),
    .need_cnt   (need_cnt),
    .lock_q     (lock_w),
    .cnt_q      (cnt_w)
  );

  pld_fb_ratio u_ratio (
    .pmode      (prescale_q),
    .a_cnt      (a_cnt_q),
    .b_cnt      (b_cnt_q),
    .p_val      (p_w),
    .bypass_a   (byp_a_w),
    .bypass_all (byp_all_w),
    .n_ratio    (n_w)
  );

  // ==========================================================
  // Divider and delay settings out
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ref_delay_code    <= '0;
      fb_delay_code     <= '0;
      fb_prescale       <= 6'h01;
      fb_swallow        <= '0;
      fb_main           <= '0;
      fixed_divide_mode <= 1'b1;
      fb_bypass_all     <= 1'b0;
      fb_ratio          <= 18'h00001;
    end
    else if (ce)
    begin
      // Code zero leaves the delay cell out of the path
      ref_delay_code    <= delay_q[R_DLY_LSB +: 3];
      fb_delay_code     <= delay_q[N_DLY_LSB +: 3];
      fb_prescale       <= p_w;
      fb_swallow        <= byp_a_w ? 6'h00 : a_cnt_q;
      fb_main           <= byp_all_w ? 13'h0001 : b_cnt_q;
      fixed_divide_mode <= byp_a_w;
      fb_bypass_all     <= byp_all_w;
      fb_ratio          <= n_w;
    end
  end

  // ==========================================================
  // Pin multiplexers
  function automatic logic pin_pick(input logic [5:0] sel,
                                    input logic       lk,
                                    input logic       cmp);
    case (sel)
      {1'b0, SEL_DIG}:    pin_pick = lk;
      {1'b0, SEL_CMP_HI}: pin_pick = cmp;
      {1'b0, SEL_CMP_LO}: pin_pick = !cmp;
      default:            pin_pick = 1'b0;
    endcase
  endfunction : pin_pick

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_pin            <= 1'b0;
      reference_monitor_pin <= 1'b0;
      digital_lock_result   <= 1'b0;
    end
    else if (ce)
    begin
      status_pin            <= pin_pick(st_sel, lock_w, lk_comparator_in);
      reference_monitor_pin <= pin_pick({1'b0, rm_sel_q}, lock_w,
                                        lk_comparator_in);
      digital_lock_result   <= lock_w;
    end
  end

  // Lock pin; analog variants exist only here
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_indicator_pin_o  <= 1'b0;
      lock_indicator_pin_oe <= 1'b1;
      lk_current_src_on     <= 1'b0;
    end
    else if (ce)
    begin
      lk_current_src_on <= 1'b0;
      case (lk_sel_q)
        LKSEL_DIG:
        begin
          lock_indicator_pin_o  <= lock_w;
          lock_indicator_pin_oe <= 1'b1;
        end
        LKSEL_ANA_N:
        begin
          lock_indicator_pin_o  <= 1'b0;
          lock_indicator_pin_oe <= cmp_mismatch;
        end
        LKSEL_ANA_P:
        begin
          lock_indicator_pin_o  <= 1'b1;
          lock_indicator_pin_oe <= cmp_mismatch;
        end
        LKSEL_CSRC:
        begin
          // Grounding whenever lock_w drops restarts the capacitor charge
          lk_current_src_on     <= lock_w;
          lock_indicator_pin_o  <= 1'b0;
          lock_indicator_pin_oe <= !lock_w;
        end
        default:
        begin
          lock_indicator_pin_o  <= 1'b0;
          lock_indicator_pin_oe <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  sequence s_good;
    cmp_event && phase_err < lock_thr;
  endsequence

  property p_lock_needs_count;
    @(posedge sys_clk) disable iff (!resetn)
    $rose(lock_w) |-> cnt_w >= need_cnt;
  endproperty
  a_lock_needs_count: assert property (p_lock_needs_count)
    else $error("lock rose before count reached");

  property p_unlock_drop;
    @(posedge sys_clk) disable iff (!resetn)
    ce && lock_w && cmp_event && phase_err > unlock_thr |=> !lock_w;
  endproperty
  a_unlock_drop: assert property (p_unlock_drop)
    else $error("lock not dropped after wide error");

  property p_hold_lock;
    @(posedge sys_clk) disable iff (!resetn)
    ce && lock_w && !lk_ctrl_q[LK_DIS_BIT] &&
      !(cmp_event && phase_err > unlock_thr) |=> lock_w;
  endproperty
  a_hold_lock: assert property (p_hold_lock)
    else $error("lock lost without wide error");

  property p_thr_order;
    @(posedge sys_clk) disable iff (!resetn)
    unlock_thr > lock_thr;
  endproperty
  a_thr_order: assert property (p_thr_order)
    else $error("unlock threshold not wider");

  property p_miss_clears;
    @(posedge sys_clk) disable iff (!resetn)
    ce && !lock_w && cmp_event && phase_err >= lock_thr |=> cnt_w == '0;
  endproperty
  a_miss_clears: assert property (p_miss_clears)
    else $error("counter not cleared on miss");

  property p_saturate;
    @(posedge sys_clk) disable iff (!resetn)
    cnt_w <= need_cnt |=> cnt_w <= need_cnt || $changed(need_cnt);
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("counter passed programmed count");

  property p_csrc_pin;
    @(posedge sys_clk) disable iff (!resetn)
    ce && lk_sel_q == LKSEL_CSRC |=>
      lk_current_src_on == $past(lock_w) &&
      lock_indicator_pin_oe == !$past(lock_w);
  endproperty
  a_csrc_pin: assert property (p_csrc_pin)
    else $error("current source pin wrong");

  property p_csrc_discharge;
    @(posedge sys_clk) disable iff (!resetn)
    ce && lk_sel_q == LKSEL_CSRC && !lock_w |=>
      lock_indicator_pin_oe && !lock_indicator_pin_o && !lk_current_src_on;
  endproperty
  a_csrc_discharge: assert property (p_csrc_discharge)
    else $error("pin not discharged on false lock");

  property p_ald_n;
    @(posedge sys_clk) disable iff (!resetn)
    ce && lk_sel_q == LKSEL_ANA_N |=>
      !lock_indicator_pin_o && lock_indicator_pin_oe == $past(cmp_mismatch);
  endproperty
  a_ald_n: assert property (p_ald_n)
    else $error("n-channel lock pin wrong");

  property p_ald_p;
    @(posedge sys_clk) disable iff (!resetn)
    ce && lk_sel_q == LKSEL_ANA_P |=>
      lock_indicator_pin_o && lock_indicator_pin_oe == $past(cmp_mismatch);
  endproperty
  a_ald_p: assert property (p_ald_p)
    else $error("p-channel lock pin wrong");

  property p_status_cmp_lo;
    @(posedge sys_clk) disable iff (!resetn)
    ce && st_sel == {1'b0, SEL_CMP_LO} |=>
      status_pin == !$past(lk_comparator_in);
  endproperty
  a_status_cmp_lo: assert property (p_status_cmp_lo)
    else $error("status pin comparator polarity wrong");

  property p_ratio;
    @(posedge sys_clk) disable iff (!resetn)
    ce && !byp_all_w ##1 ce |-> fb_ratio ==
      18'($past(p_w) * $past(b_cnt_q) +
          ($past(byp_a_w) ? 6'h0 : $past(a_cnt_q)));
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("feedback ratio wrong");

  property p_fixed_no_swallow;
    @(posedge sys_clk) disable iff (!resetn)
    ce && byp_a_w |=> fb_swallow == 6'h00;
  endproperty
  a_fixed_no_swallow: assert property (p_fixed_no_swallow)
    else $error("swallow counter used in fixed divide");

  property p_read_wait;
    @(posedge sys_clk) disable iff (!resetn)
    ce && take && !hwrite && !rd_q |=> !hreadyout ##1 (hreadyout || !ce);
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");

  cover property (@(posedge sys_clk) disable iff (!resetn) s_good ##1 s_good);

endmodule : pld_lock_top

// *** tb/pld_cap_model.sv ***
// Lock pin load: capacitor, pull resistor and pin comparator.
// Assumes pin enables from the block, pull side set by the bench.
`timescale 1ns/1ns
module pld_cap_model
#(
  parameter int FULL = 20
)
(
  input  wire logic sys_clk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic src_on,
  input  wire logic pull_up,
  output logic      pin,
  output logic      cmp_out
);
  // ==========================================================
  // Capacitor charge in cycles; a low drive empties it at once
  int chg_q;
  always_ff @(posedge sys_clk)
  begin
    if (pin_oe && !pin_o)
      chg_q <= 0;
    else if (src_on || (pin_oe && pin_o))
      chg_q <= (chg_q < FULL) ? chg_q + 1 : FULL;
  end
  // Released pin follows the pull, or the cap in source mode
  assign pin = pin_oe ? pin_o : (src_on ? (chg_q >= FULL) : pull_up);
  assign cmp_out = (chg_q >= FULL);
endmodule : pld_cap_model

// *** tb/testbench.sv ***
// Self-checking bench for the lock-detect and divider block.
// Assumes the cap model on the lock pin and one AHB-Lite master.
`timescale 1ns/1ns
module testbench;
  import pld_pkg::*;
  // ==========================================================
  // Signals
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        cmp_event = 1'b0;
  logic        mism = 1'b0;
  logic        pull_up = 1'b1;
  logic        ce = 1'b1;
  logic [11:0] haddr = 12'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  perr = 8'h0;
  logic        hreadyout, hresp, pin_o, pin_oe, src_on, stat, rmon;
  logic        dlr, fixd, byp, pin, cmpo;
  logic [31:0] hrdata, rd;
  logic [2:0]  rdly, fdly;
  logic [17:0] ratio;
  logic [5:0]  psc, swl;
  logic [12:0] mn;
  int n_mismatch = 0;
  int n_checks = 0;
  int cnt, lock, thr, unl, need, e, r, a, b, n;
  int pv[8] = '{1, 2, 3, 2, 4, 8, 16, 32};
  int cn[4] = '{LK_COUNT_0, LK_COUNT_1, LK_COUNT_2, LK_COUNT_3};

  always #50 sys_clk = ~sys_clk;

  pld_lock_top #(.CNT_W(8)) DUT (.sys_clk(sys_clk), .resetn(resetn),
    .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .cmp_event(cmp_event), .phase_err(perr), .cmp_mismatch(mism),
    .lk_comparator_in(cmpo), .lock_indicator_pin_i(pin),
    .lock_indicator_pin_o(pin_o), .lock_indicator_pin_oe(pin_oe),
    .lk_current_src_on(src_on), .status_pin(stat),
    .reference_monitor_pin(rmon), .digital_lock_result(dlr),
    .ref_delay_code(rdly), .fb_delay_code(fdly), .fb_prescale(psc),
    .fb_swallow(swl), .fb_main(mn), .fixed_divide_mode(fixd),
    .fb_bypass_all(byp), .fb_ratio(ratio));

  pld_cap_model CAP (.sys_clk(sys_clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .src_on(src_on), .pull_up(pull_up), .pin(pin), .cmp_out(cmpo));

  // ==========================================================
  // Checking and closing
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, x, s);
    end
  endtask : chk

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // ==========================================================
  // Bus master: hold each phase until hready is seen high
  task wt;
    int i;
    i = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1)
    begin
      i++;
      if (i > 20)
      begin
        n_mismatch++;
        test_done();
      end
      @(posedge sys_clk);
    end
  endtask : wt

  task bus(input logic w, input logic [9:0] idx, input int d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'h0};
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask : bus

  // ==========================================================
  // Compare event with the reference lock model
  task ev(input int x);
    cmp_event <= 1'b1;
    perr <= x[7:0];
    @(posedge sys_clk);
    cmp_event <= 1'b0;
    if (x < thr)
    begin
      cnt = (cnt < need) ? cnt + 1 : need;
      if (cnt == need)
        lock = 1;
    end
    else
    begin
      cnt = 0;
      if (x > unl)
        lock = 0;
    end
    repeat (2) @(posedge sys_clk);
    chk("lock", dlr, lock);
  endtask : ev

  task cfg(input int cc, input int rg, input int ab);
    bus(1'b1, IDX_LK_CTRL, (cc << LK_CNT_LSB) + (rg << LK_RANGE_BIT));
    bus(1'b1, IDX_STAT_SEL, 4 + ab);
    bus(1'b1, IDX_RM_SEL, 1);
    thr = (rg ? LOCK_THR_LO : LOCK_THR_HI) + ABP_STEP * ab;
    unl = 2 * thr;
    need = cn[cc];
  endtask : cfg

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h2773));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("byp", byp, 1);
    chk("ratio", ratio, 1);
    bus(1'b0, 10'h100, 0);
    chk("unmapped", rd, 0);
    // Swallow kept below main, within counter input limits
    for (int m = 0; m < 9; m++)
    begin
      b = (m == 8) ? 1 : 64 + $urandom % 4000;
      a = (m == 8) ? 0 : $urandom % 64;
      n = (m == 8) ? 1 : pv[m] * b + ((m < 3) ? 0 : a);
      bus(1'b1, IDX_PRESCALE, m % 8);
      bus(1'b1, IDX_A_CNT, a);
      bus(1'b1, IDX_B_CNT, b);
      bus(1'b0, IDX_N_RATIO, 0);
      chk("n_reg", rd, n);
      chk("ratio", ratio, n);
      chk("fixed", fixd, (m % 8) < 3);
      chk("byp", byp, m == 8);
      chk("psc", psc, pv[m % 8]);
      chk("swl", swl, (m < 3) ? 0 : a);
      chk("main", mn, b);
    end
    e = $urandom % 64;
    bus(1'b1, IDX_DELAY, e);
    repeat (2) @(posedge sys_clk);
    chk("rdly", rdly, e % 8);
    chk("fdly", fdly, e / 8);
    // Compare spacing far above the unlock window
    for (int c = 0; c < 8; c++)
    begin
      cfg(c % 4, c / 4, c % 4);
      ev(255);
      for (int i = 0; i < need + 40; i++)
      begin
        r = $urandom % 16;
        if (i < need || r > 1)
          e = $urandom % thr;
        else if (r == 1)
          e = thr + 1 + $urandom % (unl - thr);
        else
          e = unl + 1 + $urandom % (255 - unl);
        ev(e);
      end
      bus(1'b0, IDX_STATUS, 0);
      chk("cnt", rd[9:2], cnt);
    end
    cfg(0, 0, 0);
    ev(255);
    repeat (5) ev(0);
    // Low clock enable must swallow a wide compare
    ce <= 1'b0;
    cmp_event <= 1'b1;
    perr <= 8'hff;
    repeat (2) @(posedge sys_clk);
    cmp_event <= 1'b0;
    ce <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("ce_hold", dlr, lock);
    bus(1'b1, IDX_LK_SEL, LKSEL_DIG);
    repeat (2) @(posedge sys_clk);
    chk("pin", pin, 1);
    chk("stat", stat, 1);
    chk("rmon", rmon, 1);
    for (int v = 1; v < 3; v++)
    begin
      bus(1'b1, IDX_LK_SEL, v);
      pull_up <= (v == 1);
      for (int k = 0; k < 2; k++)
      begin
        mism <= k;
        repeat (3) @(posedge sys_clk);
        chk("ald", pin, (v == 1) ^ k);
      end
    end
    bus(1'b1, IDX_LK_SEL, LKSEL_CSRC);
    bus(1'b1, IDX_STAT_SEL, 8);
    bus(1'b1, IDX_RM_SEL, 3);
    repeat (30) @(posedge sys_clk);
    chk("src", src_on, 1);
    chk("stat", stat, 1);
    chk("rmon", rmon, 0);
    ev(255);
    repeat (3) @(posedge sys_clk);
    chk("src", src_on, 0);
    chk("pin", pin, 0);
    chk("stat", stat, 0);
    chk("hresp", hresp, 0);
    test_done();
  end
endmodule : testbench
